// ### acp_packer.sv
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - Cell mode with group size fixed at one connection per pseudowire.
// - OAM cells travel exactly like user cells, no filtering.
// - Ingress concatenates cells into payloads; egress splits payloads back into cells.
// - Each packed cell is 52 bytes, header without HEC.
// - A payload never holds more than 29 cells.
// - Packed payload stays below the MTU, at most 1514 bytes, whenever the MTU exceeds one cell plus control word.
// - Close packet on configured cell count or concatenation timer expiry.
// - Optionally close packet when an arriving cell changes loss priority.
// - Otherwise send as soon as another cell would reach the MTU.
// - Loss priority bit passes unchanged, even through header rewrite.
// - VC mode egress may replace both VPI and VCI.
// - VP mode egress replaces VPI only and keeps VCI.
// - Service type is 0x0009 for channel mode, 0x000A for path mode.
// - Optional control word inserted on ingress, stripped on egress.
module acp_packer
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [31:0] REG_RDATA_OUT,
    input wire acp_pkg::acp_cell_t ING_CELL_IN,
    input wire logic ING_CELL_VALID_IN,
    output logic ING_CELL_READY_OUT,
    output acp_pkg::acp_byte_t PSN_TX_OUT,
    output logic PSN_TX_VALID_OUT,
    input wire acp_pkg::acp_byte_t PSN_RX_IN,
    input wire logic PSN_RX_VALID_IN,
    output acp_pkg::acp_cell_t ATM_TX_CELL_OUT,
    output logic ATM_TX_VALID_OUT,
    output logic [15:0] SVC_TYPE_OUT
);

    typedef enum logic [0:0]
    {
        ST_COLLECT = 1'b0,
        ST_SEND = 1'b1
    } acp_state_t;

    // ==========================================================
    // Configuration registers
    // ==========================================================
    logic [3:0] ctrl_q;
    logic [4:0] max_cells_q;
    logic [15:0] timer_q;
    logic [11:0] mtu_q;
    logic [7:0] eg_vpi_q;
    logic [15:0] eg_vci_q;
    logic [15:0] ing_pkts_q;
    logic [15:0] svc_type_q;
    logic [31:0] rdata_q;
    logic [15:0] eg_cells;
    acp_pkg::acp_eg_cfg_t eg_cfg;

    // ==========================================================
    // Ingress packing state
    // ==========================================================
    acp_state_t state_q;
    acp_state_t state_d;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    logic pkt_clp_q;
    logic [4:0] pre_q;
    logic [15:0] tmr_q;
    logic [11:0] pos_q;
    logic [4:0] rd_cell_q;
    logic [5:0] rd_byte_q;
    logic [415:0] cell_mem [0:28];

    logic cw_en;
    logic [11:0] cw_len;
    logic [4:0] eff_max;
    logic [11:0] len_after_next;
    logic [11:0] tot_len;
    logic clp_break;
    logic accept;
    logic tmr_exp;
    logic full_close;
    logic close_now;
    logic in_cw;
    logic last_byte;
    logic [415:0] rd_cell;
    logic [7:0] rd_data;
    logic unit_tick;

    assign cw_en = ctrl_q[acp_pkg::CTRL_CW_EN];
    assign cw_len = cw_en ? acp_pkg::PW_CW_BYTES : 12'h000;

    // Zero or oversized limits fall back to the hard ceiling
    assign eff_max = (max_cells_q == 5'h00 || max_cells_q > acp_pkg::PAYLOAD_CELLS_MAX)
                     ? acp_pkg::PAYLOAD_CELLS_MAX : max_cells_q;

    // Size the payload would have if one more cell followed this one
    assign len_after_next = ({7'h00, cnt_q} + 12'h002) * acp_pkg::CELL_BYTES + cw_len;

    // Loss priority change ends the packet before the new cell is taken
    assign clp_break = ctrl_q[acp_pkg::CTRL_CLP_SPLIT] && (state_q == ST_COLLECT)
                       && (cnt_q != 5'h00) && (ING_CELL_IN.clp != pkt_clp_q);

    assign ING_CELL_READY_OUT = (state_q == ST_COLLECT) && !clp_break;
    assign accept = ING_CELL_VALID_IN && ING_CELL_READY_OUT;

    // A zero timer setting turns the timer condition off
    assign tmr_exp = (timer_q != 16'h0000) && (tmr_q >= timer_q) && (cnt_q != 5'h00);
    assign unit_tick = (pre_q == acp_pkg::TIMER_UNIT_LAST);

    assign full_close = ({7'h00, cnt_q} + 12'h001 >= {7'h00, eff_max})
                        || (len_after_next >= mtu_q);

    assign close_now = (state_q == ST_COLLECT)
                       && ((ING_CELL_VALID_IN && clp_break) || tmr_exp || (accept && full_close));

    // ==========================================================
    // Packet playout
    // ==========================================================
    assign tot_len = {7'h00, cnt_q} * acp_pkg::CELL_BYTES + cw_len;
    assign in_cw = (pos_q < cw_len);
    assign last_byte = (state_q == ST_SEND) && (pos_q == tot_len - 12'h001);
    assign rd_cell = cell_mem[rd_cell_q];
    assign rd_data = in_cw ? 8'h00 : rd_cell[12'd415 - {rd_byte_q, 3'b000} -: 8];

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_COLLECT:
            begin
                if (accept)
                begin
                    cnt_d = cnt_q + acp_pkg::GROUP_SIZE;
                end
                if (close_now)
                begin
                    state_d = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (last_byte)
                begin
                    state_d = ST_COLLECT;
                    cnt_d = 5'h00;
                end
            end
            default:
            begin
                state_d = ST_COLLECT;
                cnt_d = 5'h00;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (accept)
        begin
            cell_mem[cnt_q] <= ING_CELL_IN;
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            state_q <= ST_COLLECT;
            cnt_q <= 5'h00;
            pkt_clp_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (accept)
            begin
                pkt_clp_q <= ING_CELL_IN.clp;
            end
        end
    end

    // Timer runs only while a partly filled packet waits
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN || state_q == ST_SEND || cnt_q == 5'h00)
        begin
            pre_q <= 5'h00;
            tmr_q <= 16'h0000;
        end
        else
        begin
            pre_q <= unit_tick ? 5'h00 : pre_q + 5'h01;
            if (unit_tick && tmr_q != 16'hFFFF)
            begin
                tmr_q <= tmr_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN || state_q == ST_COLLECT)
        begin
            pos_q <= 12'h000;
            rd_cell_q <= 5'h00;
            rd_byte_q <= 6'h00;
        end
        else
        begin
            pos_q <= pos_q + 12'h001;
            if (!in_cw)
            begin
                rd_byte_q <= (rd_byte_q == acp_pkg::CELL_LAST_BYTE) ? 6'h00 : rd_byte_q + 6'h01;
                rd_cell_q <= (rd_byte_q == acp_pkg::CELL_LAST_BYTE) ? rd_cell_q + 5'h01 : rd_cell_q;
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            PSN_TX_OUT <= '0;
            PSN_TX_VALID_OUT <= 1'b0;
        end
        else
        begin
            PSN_TX_VALID_OUT <= (state_q == ST_SEND);
            PSN_TX_OUT.data <= (state_q == ST_SEND) ? rd_data : 8'h00;
            PSN_TX_OUT.sop <= (state_q == ST_SEND) && (pos_q == 12'h000);
            PSN_TX_OUT.eop <= last_byte;
        end
    end

    // ==========================================================
    // Egress unpacking
    // ==========================================================
    assign eg_cfg.vp_mode = ctrl_q[acp_pkg::CTRL_VP_MODE];
    assign eg_cfg.cw_en = cw_en;
    assign eg_cfg.rewrite = ctrl_q[acp_pkg::CTRL_REWRITE];
    assign eg_cfg.vpi = eg_vpi_q;
    assign eg_cfg.vci = eg_vci_q;

    acp_unpacker u_unpacker
    (
        .clk_in(SYS_CLK_IN),
        .rst_in(SYS_RST_IN),
        .cfg_in(eg_cfg),
        .rx_in(PSN_RX_IN),
        .rx_valid_in(PSN_RX_VALID_IN),
        .cell_out(ATM_TX_CELL_OUT),
        .cell_valid_out(ATM_TX_VALID_OUT),
        .cell_count_out(eg_cells)
    );

    // ==========================================================
    // Register port
    // ==========================================================
    logic wr_ctrl;
    logic wr_max;
    logic wr_timer;
    logic wr_mtu;
    logic wr_vpi;
    logic wr_vci;
    logic [31:0] rd_mux;
    logic [11:0] mtu_wr;

    assign wr_ctrl = REG_WR_IN && (REG_ADDR_IN == acp_pkg::REG_CTRL);
    assign wr_max = REG_WR_IN && (REG_ADDR_IN == acp_pkg::REG_MAX_CELLS);
    assign wr_timer = REG_WR_IN && (REG_ADDR_IN == acp_pkg::REG_TIMER);
    assign wr_mtu = REG_WR_IN && (REG_ADDR_IN == acp_pkg::REG_MTU);
    assign wr_vpi = REG_WR_IN && (REG_ADDR_IN == acp_pkg::REG_EG_VPI);
    assign wr_vci = REG_WR_IN && (REG_ADDR_IN == acp_pkg::REG_EG_VCI);

    // MTU writes above the largest permitted value are clamped
    assign mtu_wr = (REG_WDATA_IN[11:0] > acp_pkg::MTU_MAX_BYTES) ? acp_pkg::MTU_MAX_BYTES
                    : REG_WDATA_IN[11:0];

    assign rd_mux = (REG_ADDR_IN == acp_pkg::REG_CTRL) ? {28'h0000000, ctrl_q}
                  : (REG_ADDR_IN == acp_pkg::REG_MAX_CELLS) ? {27'h0000000, max_cells_q}
                  : (REG_ADDR_IN == acp_pkg::REG_TIMER) ? {16'h0000, timer_q}
                  : (REG_ADDR_IN == acp_pkg::REG_MTU) ? {20'h00000, mtu_q}
                  : (REG_ADDR_IN == acp_pkg::REG_EG_VPI) ? {24'h000000, eg_vpi_q}
                  : (REG_ADDR_IN == acp_pkg::REG_EG_VCI) ? {16'h0000, eg_vci_q}
                  : (REG_ADDR_IN == acp_pkg::REG_STATUS) ? {15'h0000, pkt_clp_q, tmr_q[7:0], 2'h0, state_q, cnt_q}
                  : (REG_ADDR_IN == acp_pkg::REG_SVC_TYPE) ? {16'h0000, svc_type_q}
                  : (REG_ADDR_IN == acp_pkg::REG_ING_PKTS) ? {16'h0000, ing_pkts_q}
                  : (REG_ADDR_IN == acp_pkg::REG_EG_CELLS) ? {16'h0000, eg_cells}
                  : 32'h00000000;

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            ctrl_q <= acp_pkg::CTRL_RESET;
            max_cells_q <= acp_pkg::MAX_CELLS_RESET;
            timer_q <= acp_pkg::TIMER_RESET;
            mtu_q <= acp_pkg::MTU_RESET;
            eg_vpi_q <= 8'h00;
            eg_vci_q <= 16'h0000;
        end
        else
        begin
            ctrl_q <= wr_ctrl ? REG_WDATA_IN[3:0] : ctrl_q;
            max_cells_q <= wr_max ? REG_WDATA_IN[4:0] : max_cells_q;
            timer_q <= wr_timer ? REG_WDATA_IN[15:0] : timer_q;
            mtu_q <= wr_mtu ? mtu_wr : mtu_q;
            eg_vpi_q <= wr_vpi ? REG_WDATA_IN[7:0] : eg_vpi_q;
            eg_vci_q <= wr_vci ? REG_WDATA_IN[15:0] : eg_vci_q;
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN)
        begin
            rdata_q <= 32'h00000000;
            svc_type_q <= acp_pkg::SVC_TYPE_VCC;
            ing_pkts_q <= 16'h0000;
        end
        else
        begin
            rdata_q <= REG_RD_IN ? rd_mux : 32'h00000000;
            svc_type_q <= ctrl_q[acp_pkg::CTRL_VP_MODE] ? acp_pkg::SVC_TYPE_VPC : acp_pkg::SVC_TYPE_VCC;
            ing_pkts_q <= last_byte ? ing_pkts_q + 16'h0001 : ing_pkts_q;
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign SVC_TYPE_OUT = svc_type_q;

endmodule

// ### acp_packer_assertions.sv
`timescale 1ns/1ns
module acp_packer_assertions
(
    input wire logic SYS_CLK_IN,
    input wire logic SYS_RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic [31:0] REG_RDATA_OUT,
    input wire logic ING_CELL_READY_OUT,
    input wire acp_pkg::acp_byte_t PSN_TX_OUT,
    input wire logic PSN_TX_VALID_OUT,
    input wire acp_pkg::acp_byte_t PSN_RX_IN,
    input wire logic PSN_RX_VALID_IN,
    input wire acp_pkg::acp_cell_t ATM_TX_CELL_OUT,
    input wire logic ATM_TX_VALID_OUT,
    input wire logic [15:0] SVC_TYPE_OUT
);
    logic [11:0] len_q;
    logic [11:0] len_d;
    logic last_w;

    // ====
    // Payload length
    // ====
    assign last_w = PSN_TX_VALID_OUT && PSN_TX_OUT.eop;
    assign len_d = len_q + 12'h001;
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (SYS_RST_IN || last_w)
            len_q <= 12'h000;
        else if (PSN_TX_VALID_OUT)
            len_q <= len_d;
    end

    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN);

    // ====
    // Properties
    // ====
    property p_svc;
        REG_WR_IN && REG_ADDR_IN == acp_pkg::REG_CTRL |-> ##2 SVC_TYPE_OUT ==
            ($past(REG_WDATA_IN[acp_pkg::CTRL_VP_MODE], 2) ? acp_pkg::SVC_TYPE_VPC : acp_pkg::SVC_TYPE_VCC);
    endproperty
    property p_len;
        last_w |-> len_d > 12'h004 && len_d <= 12'h5E8 &&
            (len_d % 12'h034 == 12'h000 || len_d % 12'h034 == 12'h004);
    endproperty
    property p_sop;
        PSN_TX_VALID_OUT |-> PSN_TX_OUT.sop == !$past(PSN_TX_VALID_OUT);
    endproperty
    property p_gap;
        PSN_TX_VALID_OUT && !PSN_TX_OUT.eop |=> PSN_TX_VALID_OUT;
    endproperty
    property p_end;
        last_w |=> !PSN_TX_VALID_OUT;
    endproperty
    property p_rdy;
        PSN_TX_VALID_OUT && !PSN_TX_OUT.eop |-> !ING_CELL_READY_OUT;
    endproperty
    property p_src;
        ATM_TX_VALID_OUT |-> $past(PSN_RX_VALID_IN) && $past(PSN_RX_VALID_IN, 52);
    endproperty
    property p_clp;
        ATM_TX_VALID_OUT |-> ATM_TX_CELL_OUT.clp == $past(PSN_RX_IN.data[0], 49);
    endproperty
    property p_pti;
        ATM_TX_VALID_OUT |-> ATM_TX_CELL_OUT.pti == $past(PSN_RX_IN.data[3:1], 49);
    endproperty

    a_svc: assert property (p_svc) else $error("service type wrong");
    a_len: assert property (p_len) else $error("payload length wrong");
    a_sop: assert property (p_sop) else $error("start flag wrong");
    a_gap: assert property (p_gap) else $error("gap in payload");
    a_end: assert property (p_end) else $error("no gap after packet");
    a_rdy: assert property (p_rdy) else $error("cell taken in playout");
    a_src: assert property (p_src) else $error("egress cell unsourced");
    a_clp: assert property (p_clp) else $error("loss priority changed");
    a_pti: assert property (p_pti) else $error("cell type changed");

    c_pkt: cover property (last_w);
    c_cell: cover property (ATM_TX_VALID_OUT);
    c_read: cover property (REG_RD_IN ##1 REG_RDATA_OUT != 32'h0);
endmodule

// ### acp_pkg.sv
package acp_pkg;

    // ==========================================================
    // Cell and payload geometry
    // ==========================================================
    localparam int CELL_BITS = 416;
    localparam logic [11:0] CELL_BYTES = 12'h034;
    localparam logic [5:0] CELL_LAST_BYTE = 6'h33;
    localparam logic [4:0] PAYLOAD_CELLS_MAX = 5'h1D;
    localparam logic [11:0] MTU_MAX_BYTES = 12'h5EA;
    localparam logic [11:0] PW_CW_BYTES = 12'h004;
    localparam logic [4:0] GROUP_SIZE = 5'h01;

    // ==========================================================
    // Service types as signalled
    // ==========================================================
    localparam logic [15:0] SVC_TYPE_VCC = 16'h0009;
    localparam logic [15:0] SVC_TYPE_VPC = 16'h000A;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS = 50;
    localparam int TIMER_UNIT_NS = 1000;
    localparam int TIMER_UNIT_CYC = TIMER_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [4:0] TIMER_UNIT_LAST = 5'(TIMER_UNIT_CYC - 1);

    // ==========================================================
    // Register offsets
    // ==========================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_MAX_CELLS = 8'h04;
    localparam logic [7:0] REG_TIMER = 8'h08;
    localparam logic [7:0] REG_MTU = 8'h0C;
    localparam logic [7:0] REG_EG_VPI = 8'h10;
    localparam logic [7:0] REG_EG_VCI = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_SVC_TYPE = 8'h1C;
    localparam logic [7:0] REG_ING_PKTS = 8'h20;
    localparam logic [7:0] REG_EG_CELLS = 8'h24;

    // Control register fields
    localparam int CTRL_VP_MODE = 0;
    localparam int CTRL_CW_EN = 1;
    localparam int CTRL_CLP_SPLIT = 2;
    localparam int CTRL_REWRITE = 3;

    // Reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [4:0] MAX_CELLS_RESET = 5'h01;
    localparam logic [15:0] TIMER_RESET = 16'h0064;
    localparam logic [11:0] MTU_RESET = 12'h5EA;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic [3:0] gfc;
        logic [7:0] vpi;
        logic [15:0] vci;
        logic [2:0] pti;
        logic clp;
        logic [47:0][7:0] payload;
    } acp_cell_t;

    typedef struct packed {
        logic sop;
        logic eop;
        logic [7:0] data;
    } acp_byte_t;

    typedef struct packed {
        logic vp_mode;
        logic cw_en;
        logic rewrite;
        logic [7:0] vpi;
        logic [15:0] vci;
    } acp_eg_cfg_t;

endpackage

// ### acp_psn_loop.sv
`timescale 1ns/1ns
module acp_psn_loop
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire acp_pkg::acp_byte_t tx_in,
    input wire logic tx_valid_in,
    output acp_pkg::acp_byte_t rx_out,
    output logic rx_valid_out
);
    // ====
    // Tunnel, one cycle of delay
    // ====
    // Each idle cycle inverts the held byte and flags again so a stale byte never passes for data
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rx_out <= '0;
            rx_valid_out <= 1'b0;
        end
        else
        begin
            rx_valid_out <= tx_valid_in;
            rx_out <= tx_valid_in ? tx_in : ~rx_out;
        end
    end
endmodule

// ### acp_unpacker.sv
`timescale 1ns/1ns
module acp_unpacker
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire acp_pkg::acp_eg_cfg_t cfg_in,
    input wire acp_pkg::acp_byte_t rx_in,
    input wire logic rx_valid_in,
    output acp_pkg::acp_cell_t cell_out,
    output logic cell_valid_out,
    output logic [15:0] cell_count_out
);

    // ==========================================================
    // Byte position within the received payload
    // ==========================================================
    logic [2:0] cw_left_q;
    logic [2:0] cw_left_d;
    logic [5:0] byte_q;
    logic [5:0] byte_d;
    logic [415:0] shift_q;
    logic [415:0] shift_d;
    logic in_cw;
    logic take;
    logic cell_done;
    acp_pkg::acp_cell_t raw_cell;
    acp_pkg::acp_cell_t new_cell;

    // A fresh packet restarts the control-word skip, and restarts the cell cut only when the control word is on
    assign in_cw = rx_in.sop ? cfg_in.cw_en : (cw_left_q != 3'h0);
    assign take = rx_valid_in && !in_cw;
    assign cell_done = take && (byte_q == acp_pkg::CELL_LAST_BYTE);
    assign shift_d = take ? {shift_q[407:0], rx_in.data} : shift_q;
    assign raw_cell = acp_pkg::acp_cell_t'(shift_d);

    always_comb
    begin
        cw_left_d = cw_left_q;
        byte_d = byte_q;
        if (rx_valid_in)
        begin
            if (rx_in.sop)
            begin
                byte_d = 6'h00;
                cw_left_d = cfg_in.cw_en ? 3'h3 : 3'h0;
            end
            else if (cw_left_q != 3'h0)
            begin
                cw_left_d = cw_left_q - 3'h1;
            end
            if (take)
            begin
                byte_d = cell_done ? 6'h00 : byte_q + 6'h01;
            end
            // A trailing partial cell is discarded at packet end
            if (rx_in.eop)
            begin
                byte_d = 6'h00;
            end
        end
    end

    // ==========================================================
    // Header rewrite; loss priority and PTI stay as received
    // ==========================================================
    always_comb
    begin
        new_cell = raw_cell;
        if (cfg_in.rewrite)
        begin
            new_cell.vpi = cfg_in.vpi;
            if (!cfg_in.vp_mode)
            begin
                new_cell.vci = cfg_in.vci;
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cw_left_q <= 3'h0;
            byte_q <= 6'h00;
            shift_q <= '0;
            cell_out <= '0;
            cell_valid_out <= 1'b0;
            cell_count_out <= 16'h0000;
        end
        else
        begin
            cw_left_q <= cw_left_d;
            byte_q <= byte_d;
            shift_q <= shift_d;
            cell_valid_out <= cell_done;
            if (cell_done)
            begin
                cell_out <= new_cell;
                cell_count_out <= cell_count_out + 16'h0001;
            end
        end
    end

endmodule

// ### tb.sv
`timescale 1ns/1ns
module tb;
    localparam logic [31:0] VP = 32'h1 << acp_pkg::CTRL_VP_MODE;
    localparam logic [31:0] CW = 32'h1 << acp_pkg::CTRL_CW_EN;
    localparam logic [31:0] SPL = 32'h1 << acp_pkg::CTRL_CLP_SPLIT;
    localparam logic [31:0] RW = 32'h1 << acp_pkg::CTRL_REWRITE;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_p = 1'b0;
    logic cv = 1'b0;
    logic crdy, txv, rxv, ev;
    logic [31:0] rdat, ctl, vpi, vci;
    logic [15:0] svc;
    acp_pkg::acp_cell_t cin = '0;
    acp_pkg::acp_cell_t ecell;
    acp_pkg::acp_byte_t tx, rx;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rq[$];
    acp_pkg::acp_byte_t bq[$];
    acp_pkg::acp_cell_t cq[$], pk[$];
    logic [31:0] sc[4] = '{32'h0, CW, CW | RW, VP | RW};
    int nc[4] = '{1, 3, 1, 2};

    always #25 clk = ~clk;

    acp_packer i_dut
    (
        .SYS_CLK_IN(clk),
        .SYS_RST_IN(rst),
        .REG_ADDR_IN(adr),
        .REG_WDATA_IN(wd),
        .REG_WR_IN(wr),
        .REG_RD_IN(rd),
        .REG_RDATA_OUT(rdat),
        .ING_CELL_IN(cin),
        .ING_CELL_VALID_IN(cv),
        .ING_CELL_READY_OUT(crdy),
        .PSN_TX_OUT(tx),
        .PSN_TX_VALID_OUT(txv),
        .PSN_RX_IN(rx),
        .PSN_RX_VALID_IN(rxv),
        .ATM_TX_CELL_OUT(ecell),
        .ATM_TX_VALID_OUT(ev),
        .SVC_TYPE_OUT(svc)
    );
    acp_psn_loop i_psn
    (
        .clk_in(clk),
        .rst_in(rst),
        .tx_in(tx),
        .tx_valid_in(txv),
        .rx_out(rx),
        .rx_valid_out(rxv)
    );

    // ====
    // Compare and report
    // ====
    task cmp(input logic [415:0] g, input logic [415:0] e);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task chk_w(input logic [31:0] g, input logic [31:0] e);
        cmp(416'(g), 416'(e));
    endtask
    task chk_b(input acp_pkg::acp_byte_t g, input acp_pkg::acp_byte_t e);
        cmp(416'(g), 416'(e));
    endtask
    task chk_c(input acp_pkg::acp_cell_t g, input acp_pkg::acp_cell_t e);
        cmp(416'(g), 416'(e));
    endtask
    task close_out();
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ====
    // Drivers
    // ====
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        adr <= a;
        rd <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task cfg(input logic [31:0] c, input logic [31:0] m, input logic [31:0] t, input logic [31:0] u);
        ctl = c;
        wr_reg(acp_pkg::REG_CTRL, c);
        wr_reg(acp_pkg::REG_MAX_CELLS, m);
        wr_reg(acp_pkg::REG_TIMER, t);
        wr_reg(acp_pkg::REG_MTU, u);
    endtask
    function automatic acp_pkg::acp_cell_t rnd();
        acp_pkg::acp_cell_t c;
        for (int i = 0; i < 13; i++)
            c[i * 32 +: 32] = $urandom;
        return c;
    endfunction
    // Valid stays up between cells so back-to-back cells need no idle cycle
    task send(input acp_pkg::acp_cell_t c);
        cin <= c;
        cv <= 1'b1;
        pk.push_back(c);
        @(negedge clk);
        while (crdy !== 1'b1)
            @(negedge clk);
        @(posedge clk);
    endtask
    task pkt();
        int w;
        int n;
        acp_pkg::acp_byte_t b;
        acp_pkg::acp_cell_t e;
        w = ctl[acp_pkg::CTRL_CW_EN] ? 4 : 0;
        n = w + 52 * pk.size();
        for (int i = 0; i < n; i++)
        begin
            e = pk[(i < w) ? 0 : (i - w) / 52];
            b.sop = (i == 0);
            b.eop = (i == n - 1);
            b.data = (i < w) ? 8'h00 : e[415 - 8 * ((i - w) % 52) -: 8];
            bq.push_back(b);
        end
        foreach (pk[k])
        begin
            e = pk[k];
            if (ctl[acp_pkg::CTRL_REWRITE])
                e.vpi = vpi[7:0];
            if (ctl[acp_pkg::CTRL_REWRITE] && !ctl[acp_pkg::CTRL_VP_MODE])
                e.vci = vci[15:0];
            cq.push_back(e);
        end
        pk.delete();
    endtask
    task drain();
        cv <= 1'b0;
        while (bq.size() + cq.size() > 0)
            @(posedge clk);
        @(posedge clk);
    endtask

    // ====
    // Monitors and watchdog
    // ====
    always @(posedge clk)
        rd_p <= rd;
    always @(negedge clk)
    begin
        if (rd_p)
            chk_w(rdat, rq.pop_front());
        if (txv)
            chk_b(tx, bq.pop_front());
        if (ev)
            chk_c(ecell, cq.pop_front());
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            close_out();
        end
    end

    initial
    begin
        acp_pkg::acp_cell_t c;
        void'($urandom(55));
        vpi = $urandom & 32'hFF;
        vci = $urandom & 32'hFFFF;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(acp_pkg::REG_MTU, 32'(acp_pkg::MTU_MAX_BYTES));
        wr_reg(acp_pkg::REG_MTU, 32'hFFF);
        rd_reg(acp_pkg::REG_MTU, 32'(acp_pkg::MTU_MAX_BYTES));
        wr_reg(acp_pkg::REG_SVC_TYPE, 32'hFFFF);
        rd_reg(acp_pkg::REG_SVC_TYPE, 32'(acp_pkg::SVC_TYPE_VCC));
        rd_reg(8'h3C, 32'h0);
        wr_reg(acp_pkg::REG_EG_VPI, vpi);
        wr_reg(acp_pkg::REG_EG_VCI, vci);
        // Two packets back to back per mode, each opened by a maintenance cell
        foreach (sc[k])
        begin
            cfg(sc[k], nc[k], 0, 1514);
            chk_w(32'(svc), 32'(sc[k][0] ? acp_pkg::SVC_TYPE_VPC : acp_pkg::SVC_TYPE_VCC));
            for (int p = 0; p < 2; p++)
            begin
                for (int i = 0; i < nc[k]; i++)
                begin
                    c = rnd();
                    c.pti = (i == 0) ? 3'h4 : c.pti;
                    send(c);
                end
                pkt();
            end
            drain();
        end
        // Priority change closes early; the timer then starts afresh for the next cells
        cfg(SPL, 4, 2, 1514);
        c = rnd();
        c.clp = 1'b0;
        send(c);
        pkt();
        c.clp = 1'b1;
        send(c);
        send(c);
        pkt();
        drain();
        cfg(32'h0, 0, 0, 160);
        repeat (3) send(rnd());
        pkt();
        drain();
        cfg(CW, 31, 0, 1514);
        repeat (29) send(rnd());
        pkt();
        drain();
        rd_reg(acp_pkg::REG_ING_PKTS, 32'h0C);
        rd_reg(acp_pkg::REG_EG_CELLS, 32'h31);
        close_out();
    end
endmodule

bind acp_packer acp_packer_assertions i_chk
(
    .SYS_CLK_IN(SYS_CLK_IN),
    .SYS_RST_IN(SYS_RST_IN),
    .REG_ADDR_IN(REG_ADDR_IN),
    .REG_WDATA_IN(REG_WDATA_IN),
    .REG_WR_IN(REG_WR_IN),
    .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT),
    .ING_CELL_READY_OUT(ING_CELL_READY_OUT),
    .PSN_TX_OUT(PSN_TX_OUT),
    .PSN_TX_VALID_OUT(PSN_TX_VALID_OUT),
    .PSN_RX_IN(PSN_RX_IN),
    .PSN_RX_VALID_IN(PSN_RX_VALID_IN),
    .ATM_TX_CELL_OUT(ATM_TX_CELL_OUT),
    .ATM_TX_VALID_OUT(ATM_TX_VALID_OUT),
    .SVC_TYPE_OUT(SVC_TYPE_OUT)
);
